// *** pkg/keyer_pkg.sv ***
// Constants shared by the signal keyer: register indices, field positions,
// reset values and source selection codes.
// Assumes a 32-bit classic Wishbone slave with one register per aligned word.
package keyer_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_CONTROL_ZERO = 14'hf51;
  localparam logic [13:0] IDX_CONTROL_ONE  = 14'hf52;
  localparam logic [13:0] IDX_DATA_SOURCE  = 14'hf53;
  localparam logic [13:0] IDX_LOW_CARRIER  = 14'hf54;
  localparam logic [13:0] IDX_HIGH_CARRIER = 14'hf55;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int POS_ENABLE      = 7;
  localparam int POS_OUT_STATUS  = 5;
  localparam int POS_RESULT_INV  = 4;
  localparam int POS_SOFT_KEY    = 0;
  localparam int POS_HIGH_INV    = 5;
  localparam int POS_HIGH_ALIGN  = 4;
  localparam int POS_LOW_INV     = 1;
  localparam int POS_LOW_ALIGN   = 0;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] RST_CONTROL_ONE  = 8'h00;
  localparam logic [4:0] RST_DATA_SOURCE  = 5'h00;
  localparam logic [3:0] RST_CARRIER      = 4'h0;

  // ----------------------------------------------------------------
  // Data source codes; codes above the last one are reserved.
  // ----------------------------------------------------------------
  localparam logic [4:0] SRC_PIN      = 5'h00;
  localparam logic [4:0] SRC_SOFT     = 5'h01;
  localparam logic [4:0] SRC_CCP_BASE = 5'h02;
  localparam logic [4:0] SRC_PWM_BASE = 5'h07;
  localparam logic [4:0] SRC_CMP_BASE = 5'h09;
  localparam logic [4:0] SRC_SER_BASE = 5'h0c;
  localparam logic [4:0] SRC_SSP_BASE = 5'h16;
  localparam logic [4:0] SRC_LAST     = 5'h17;

  // ----------------------------------------------------------------
  // Carrier source codes, shared by both carrier fields.
  // ----------------------------------------------------------------
  localparam logic [3:0] CAR_PIN      = 4'h0;
  localparam logic [3:0] CAR_SYSCLK   = 4'h1;
  localparam logic [3:0] CAR_FAST_OSC = 4'h2;
  localparam logic [3:0] CAR_REF_CLK  = 4'h3;
  localparam logic [3:0] CAR_CCP_BASE = 4'h4;
  localparam logic [3:0] CAR_PWM_BASE = 4'h9;
  localparam logic [3:0] CAR_LAST     = 4'ha;

  // ----------------------------------------------------------------
  // Which carrier currently feeds the output.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SIDE_LOW  = 2'b01,
    SIDE_HIGH = 2'b10
  } side_t;

endpackage : keyer_pkg

// *** src/level_sync.sv ***
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level or a clock-like signal from another domain.
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // ----------------------------------------------------------------
  // Sync chain.
  // ----------------------------------------------------------------
  // The first stage feeds only the second, so metastability settles there.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule : level_sync

// *** src/carrier_pick.sv ***
// Carrier source selector with optional inversion.
// Assumes all sources are already in the mclk domain.
`timescale 1ns/1ps
module carrier_pick
  import keyer_pkg::*;
(
  // Candidate sources, indexed by selection code.
  input  wire logic [10:0] sources,
  // Control.
  input  wire logic [3:0]  select,
  input  wire logic        invert,
  // Chosen carrier.
  output logic             carrier
);

  // ----------------------------------------------------------------
  // Selection.
  // ----------------------------------------------------------------
  // Reserved codes give a quiet zero before inversion.
  always_comb begin
    if (select <= CAR_LAST) begin
      carrier = sources[select] ^ invert;
    end else begin
      carrier = invert;
    end
  end

endmodule : carrier_pick

// *** src/signal_keyer.sv ***
// Signal keyer: mixes a data signal with one of two carriers into one
// keyed output, with per-carrier alignment, inversions and output polarity.
// Assumes a classic Wishbone master on mclk, peripheral sources on mclk and
// pin or oscillator sources asynchronous to it.
`timescale 1ns/1ps
module signal_keyer
  import keyer_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Wishbone slave.
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Asynchronous sources: remapped pins and clocks.
  input  wire logic              data_input_remap,
  input  wire logic              upper_carrier_input_remap,
  input  wire logic              lower_carrier_input_remap,
  input  wire logic              system_clock_source,
  input  wire logic              fast_internal_oscillator,
  input  wire logic              reference_clock_output,
  // Peripheral sources on mclk.
  input  wire logic [4:0]        capture_compare_out,
  input  wire logic [1:0]        pulse_width_gen_out,
  input  wire logic [2:0]        comparator_out,
  input  wire logic [4:0]        serial_port_data_out,
  input  wire logic [4:0]        serial_port_clock_out,
  input  wire logic [1:0]        sync_serial_port_out,
  // Keyed result towards the pin remapping stage.
  output logic                   keyed_result_pin
);

  // ----------------------------------------------------------------
  // Elaboration check.
  // ----------------------------------------------------------------
  if (ADDR_W < 16) begin : g_addr_check
    $error("signal_keyer: ADDR_W must be at least 16");
  end

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  // Software state.
  logic        enable;
  logic        result_invert;
  logic        software_keying_flag;
  logic        high_carrier_invert;
  logic        high_carrier_align;
  logic        low_carrier_invert;
  logic        low_carrier_align;
  logic [4:0]  data_source_field;
  logic [3:0]  high_carrier_field;
  logic [3:0]  low_carrier_field;
  logic        next_enable;
  logic        next_result_invert;
  logic        next_software_keying_flag;
  logic        next_high_carrier_invert;
  logic        next_high_carrier_align;
  logic        next_low_carrier_invert;
  logic        next_low_carrier_align;
  logic [4:0]  next_data_source_field;
  logic [3:0]  next_high_carrier_field;
  logic [3:0]  next_low_carrier_field;
  // Bus state.
  logic        next_ack;
  logic [31:0] next_dat;
  logic        bus_write;
  // Synchronised inputs.
  logic [5:0]  pin_sync;
  // Source vectors and selections.
  logic [23:0] data_sources;
  logic [10:0] upper_sources;
  logic [10:0] lower_sources;
  logic        data_keying_signal;
  logic        upper_carrier_signal;
  logic        lower_carrier_signal;
  // Keying state.
  side_t       side;
  side_t       next_side;
  side_t       use_side;
  logic        next_keyed;

  // ----------------------------------------------------------------
  // Index decode.
  // ----------------------------------------------------------------
  // Only word-aligned accesses reach a register; the upper address bits
  // above the index must be zero for a match.
  function automatic logic [13:0] to_index(input logic [ADDR_W-1:0] adr);
    to_index = adr[15:2];
  endfunction : to_index

  function automatic logic hits(input logic [ADDR_W-1:0] adr,
                                input logic [13:0] idx);
    hits = (to_index(adr) == idx) && (adr[1:0] == 2'b00) &&
           ((adr >> 16) == '0);
  endfunction : hits

  // ----------------------------------------------------------------
  // Wishbone handshake.
  // ----------------------------------------------------------------
  // Answer one edge after the request; ack drops the next cycle because
  // it is only raised while ack is low. A write takes effect at the edge
  // where the master sees ack high. Unmapped words answer with zero.
  assign bus_write = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  always_comb begin
    next_ack = cyc_i && stb_i && !ack_o;
    next_dat = 32'h0000_0000;
    if (cyc_i && stb_i && !ack_o && !we_i) begin
      if (hits(adr_i, IDX_CONTROL_ZERO)) begin
        next_dat[POS_ENABLE]     = enable;
        next_dat[POS_OUT_STATUS] = keyed_result_pin;
        next_dat[POS_RESULT_INV] = result_invert;
        next_dat[POS_SOFT_KEY]   = software_keying_flag;
      end else if (hits(adr_i, IDX_CONTROL_ONE)) begin
        next_dat[POS_HIGH_INV]   = high_carrier_invert;
        next_dat[POS_HIGH_ALIGN] = high_carrier_align;
        next_dat[POS_LOW_INV]    = low_carrier_invert;
        next_dat[POS_LOW_ALIGN]  = low_carrier_align;
      end else if (hits(adr_i, IDX_DATA_SOURCE)) begin
        next_dat[4:0] = data_source_field;
      end else if (hits(adr_i, IDX_LOW_CARRIER)) begin
        next_dat[3:0] = low_carrier_field;
      end else if (hits(adr_i, IDX_HIGH_CARRIER)) begin
        next_dat[3:0] = high_carrier_field;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------
  // Clearing enable leaves every selection untouched, so setting it again
  // resumes with the same sources. The status bit is read-only.
  always_comb begin
    next_enable               = enable;
    next_result_invert        = result_invert;
    next_software_keying_flag = software_keying_flag;
    next_high_carrier_invert  = high_carrier_invert;
    next_high_carrier_align   = high_carrier_align;
    next_low_carrier_invert   = low_carrier_invert;
    next_low_carrier_align    = low_carrier_align;
    next_data_source_field    = data_source_field;
    next_high_carrier_field   = high_carrier_field;
    next_low_carrier_field    = low_carrier_field;
    if (bus_write) begin
      if (hits(adr_i, IDX_CONTROL_ZERO)) begin
        next_enable               = dat_i[POS_ENABLE];
        next_result_invert        = dat_i[POS_RESULT_INV];
        next_software_keying_flag = dat_i[POS_SOFT_KEY];
      end else if (hits(adr_i, IDX_CONTROL_ONE)) begin
        next_high_carrier_invert  = dat_i[POS_HIGH_INV];
        next_high_carrier_align   = dat_i[POS_HIGH_ALIGN];
        next_low_carrier_invert   = dat_i[POS_LOW_INV];
        next_low_carrier_align    = dat_i[POS_LOW_ALIGN];
      end else if (hits(adr_i, IDX_DATA_SOURCE)) begin
        next_data_source_field    = dat_i[4:0];
      end else if (hits(adr_i, IDX_LOW_CARRIER)) begin
        next_low_carrier_field    = dat_i[3:0];
      end else if (hits(adr_i, IDX_HIGH_CARRIER)) begin
        next_high_carrier_field   = dat_i[3:0];
      end
    end
  end

  // Every register returns to its default on reset.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enable               <= RST_CONTROL_ZERO[POS_ENABLE];
      result_invert        <= RST_CONTROL_ZERO[POS_RESULT_INV];
      software_keying_flag <= RST_CONTROL_ZERO[POS_SOFT_KEY];
      high_carrier_invert  <= RST_CONTROL_ONE[POS_HIGH_INV];
      high_carrier_align   <= RST_CONTROL_ONE[POS_HIGH_ALIGN];
      low_carrier_invert   <= RST_CONTROL_ONE[POS_LOW_INV];
      low_carrier_align    <= RST_CONTROL_ONE[POS_LOW_ALIGN];
      data_source_field    <= RST_DATA_SOURCE;
      high_carrier_field   <= RST_CARRIER;
      low_carrier_field    <= RST_CARRIER;
    end else begin
      enable               <= next_enable;
      result_invert        <= next_result_invert;
      software_keying_flag <= next_software_keying_flag;
      high_carrier_invert  <= next_high_carrier_invert;
      high_carrier_align   <= next_high_carrier_align;
      low_carrier_invert   <= next_low_carrier_invert;
      low_carrier_align    <= next_low_carrier_align;
      data_source_field    <= next_data_source_field;
      high_carrier_field   <= next_high_carrier_field;
      low_carrier_field    <= next_low_carrier_field;
    end
  end

  // ----------------------------------------------------------------
  // Source capture.
  // ----------------------------------------------------------------
  // Pins and foreign clocks are sampled at mclk, so a clock-like carrier
  // faster than half of mclk aliases; that is the price of one domain.
  level_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({reference_clock_output, fast_internal_oscillator,
                system_clock_source, lower_carrier_input_remap,
                upper_carrier_input_remap, data_input_remap}),
    .sync_out (pin_sync)
  );

  // Data source vector in code order; serial ports interleave data, clock.
  always_comb begin
    data_sources       = '0;
    data_sources[0]    = pin_sync[0];
    data_sources[1]    = software_keying_flag;
    data_sources[6:2]  = capture_compare_out;
    data_sources[8:7]  = pulse_width_gen_out;
    data_sources[11:9] = comparator_out;
    for (int i = 0; i < 5; i++) begin
      data_sources[12 + 2 * i] = serial_port_data_out[i];
      data_sources[13 + 2 * i] = serial_port_clock_out[i];
    end
    data_sources[23:22] = sync_serial_port_out;
  end

  // Reserved codes keep the data line low.
  always_comb begin
    if (data_source_field <= SRC_LAST) begin
      data_keying_signal = data_sources[data_source_field];
    end else begin
      data_keying_signal = 1'b0;
    end
  end

  // Carrier vectors differ only in the pin at code zero.
  assign upper_sources = {pulse_width_gen_out, capture_compare_out,
                          pin_sync[5], pin_sync[4], pin_sync[3], pin_sync[1]};
  assign lower_sources = {pulse_width_gen_out, capture_compare_out,
                          pin_sync[5], pin_sync[4], pin_sync[3], pin_sync[2]};

  carrier_pick u_upper_pick (
    .sources (upper_sources),
    .select  (high_carrier_field),
    .invert  (high_carrier_invert),
    .carrier (upper_carrier_signal)
  );

  carrier_pick u_lower_pick (
    .sources (lower_sources),
    .select  (low_carrier_field),
    .invert  (low_carrier_invert),
    .carrier (lower_carrier_signal)
  );

  // ----------------------------------------------------------------
  // Carrier side tracking.
  // ----------------------------------------------------------------
  // A switch away from a side waits, if that side's align bit is set,
  // until its carrier is low, so the running pulse is never cut short.
  // Without alignment the switch follows the data level at once.
  always_comb begin
    use_side = side;
    unique case (side)
      SIDE_HIGH: begin
        if (!data_keying_signal &&
            (!high_carrier_align || !upper_carrier_signal)) begin
          use_side = SIDE_LOW;
        end
      end
      SIDE_LOW: begin
        if (data_keying_signal &&
            (!low_carrier_align || !lower_carrier_signal)) begin
          use_side = SIDE_HIGH;
        end
      end
      default: begin
        use_side = data_keying_signal ? SIDE_HIGH : SIDE_LOW;
      end
    endcase
    next_side = use_side;
  end

  // ----------------------------------------------------------------
  // Keyed output.
  // ----------------------------------------------------------------
  // High side: carrier ANDed with data; low side: carrier ANDed with the
  // inverted data, held over while an aligned pulse completes. Disabled
  // output is forced low whatever the result polarity.
  always_comb begin
    if (!enable) begin
      next_keyed = 1'b0;
    end else if (use_side == SIDE_HIGH) begin
      next_keyed = (upper_carrier_signal &
                    (data_keying_signal | (side == SIDE_HIGH)))
                   ^ result_invert;
    end else begin
      next_keyed = (lower_carrier_signal &
                    (!data_keying_signal | (side == SIDE_LOW)))
                   ^ result_invert;
    end
  end

  // The output is registered so the remap stage sees a clean level.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      side             <= SIDE_LOW;
      keyed_result_pin <= 1'b0;
    end else begin
      side             <= next_side;
      keyed_result_pin <= next_keyed;
    end
  end

endmodule : signal_keyer

// *** bench/keyer_sources.sv ***
// Far-side model of the peripherals and pins that feed the keyer.
// Assumes the bench hands over the wanted source levels as one vector.
`timescale 1ns/1ps
module keyer_sources (
  // Clock and wanted levels.
  input  wire logic        mclk,
  input  wire logic [27:0] pat,
  // Source levels, in the bench's bit layout.
  output logic      [27:0] src
);
  logic [27:0] next_src;

  // Peripherals move just after an edge, as same-domain outputs do.
  always_comb begin
    next_src = pat;
  end

  always_ff @(posedge mclk) begin
    src <= next_src;
  end
endmodule : keyer_sources

// *** bench/signal_keyer_properties.sv ***
// Bus and output checks for the signal keyer, bound to its top module.
// Assumes one clock, mclk, and the asynchronous reset sys_rst.
`timescale 1ns/1ps
module signal_keyer_properties
  import keyer_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  input wire logic              keyed_result_pin
);
  logic hit0;
  logic en_seen;
  logic next_en_seen;

  // Shadow of the enable bit, taken from completed writes only.
  assign hit0 = adr_i == ADDR_W'({IDX_CONTROL_ZERO, 2'b00});
  always_comb begin
    next_en_seen = en_seen;
    if (ack_o && cyc_i && stb_i && we_i && sel_i[0] && hit0) begin
      next_en_seen = dat_i[POS_ENABLE];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      en_seen <= 1'b0;
    end else begin
      en_seen <= next_en_seen;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack stood for more than one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  read_quiet_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  read_width_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  idle_low_a: assert property (!en_seen && !$past(en_seen) |-> !keyed_result_pin)
    else $error("keyed output high while disabled");
  enable_read_a: assert property (ack_o && !we_i && hit0 |-> dat_o[7] == en_seen)
    else $error("enable bit reads wrong");
  status_read_a: assert property (ack_o && !we_i && hit0 |->
    dat_o[POS_OUT_STATUS] == $past(keyed_result_pin))
    else $error("status bit differs from output");
endmodule : signal_keyer_properties

bind signal_keyer signal_keyer_properties #(.ADDR_W(ADDR_W)) props (
  .mclk, .sys_rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .keyed_result_pin);

// *** bench/signal_keyer_tb.sv ***
// Self-checking bench for the signal keyer; every keyed result is read back
// through the status bit. Assumes the source model and the bound checker.
`timescale 1ns/1ps
module signal_keyer_tb;
  import keyer_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [15:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        keyed_result_pin;
  logic [27:0] pat = '0;
  logic [27:0] src;
  logic [7:0]  c0, c1;
  logic [4:0]  ds;
  logic [3:0]  lc, hc;
  logic [7:0]  expq[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          r;
  logic [13:0] idx [6] = '{IDX_CONTROL_ZERO, IDX_CONTROL_ONE, IDX_DATA_SOURCE,
                           IDX_LOW_CARRIER, IDX_HIGH_CARRIER, 14'hf56};

  // Core clock, 8 ns period.
  always #4 mclk = ~mclk;

  keyer_sources far (.mclk(mclk), .pat(pat), .src(src));
  signal_keyer #(.ADDR_W(16)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .data_input_remap(src[22]), .upper_carrier_input_remap(src[23]),
    .lower_carrier_input_remap(src[24]), .system_clock_source(src[25]),
    .fast_internal_oscillator(src[26]), .reference_clock_output(src[27]),
    .capture_compare_out(src[4:0]), .pulse_width_gen_out(src[6:5]),
    .comparator_out(src[9:7]),
    .serial_port_data_out({src[18], src[16], src[14], src[12], src[10]}),
    .serial_port_clock_out({src[19], src[17], src[15], src[13], src[11]}),
    .sync_serial_port_out(src[21:20]), .keyed_result_pin(keyed_result_pin));

  // Source layout makes data codes 2 to 23 land on pattern bit code-2.
  function automatic logic dpick(input logic [4:0] c);
    if (c == SRC_PIN) return pat[22];
    if (c == SRC_SOFT) return c0[POS_SOFT_KEY];
    if (c <= SRC_LAST) return pat[c - 2];
    return 1'b0;
  endfunction : dpick

  function automatic logic cpick(input logic [3:0] c, input logic pin);
    if (c == CAR_PIN) return pin;
    if (c < CAR_CCP_BASE) return pat[24 + c];
    if (c <= CAR_LAST) return pat[c - 4];
    return 1'b0;
  endfunction : cpick

  // Expected control byte with the status bit, carriers switching at once.
  function automatic logic [7:0] ctl0_exp();
    logic k;
    k = dpick(ds) ? cpick(hc, pat[23]) ^ c1[POS_HIGH_INV]
                  : cpick(lc, pat[24]) ^ c1[POS_LOW_INV];
    k = c0[POS_ENABLE] & (k ^ c0[POS_RESULT_INV]);
    return {c0[7:6], k, c0[4:0]};
  endfunction : ctl0_exp

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // One classic cycle; held until ack is sampled, then released.
  task automatic wb(input logic w, input logic [13:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    // A bus that never answers is a failure, not a silent skip.
    if (ack_o !== 1'b1) begin
      fail_count++;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [13:0] i, input logic [7:0] e);
    expq.push_back(e);
    wb(1'b0, i, 8'h00);
  endtask : rd

  task automatic cfg();
    wb(1'b1, IDX_CONTROL_ONE, c1);
    wb(1'b1, IDX_DATA_SOURCE, {3'b0, ds});
    wb(1'b1, IDX_LOW_CARRIER, {4'h0, lc});
    wb(1'b1, IDX_HIGH_CARRIER, {4'h0, hc});
    wb(1'b1, IDX_CONTROL_ZERO, c0);
  endtask : cfg

  // Pins need extra synchroniser cycles, so let everything settle first.
  task automatic look(input logic [7:0] e);
    repeat (6) @(posedge mclk);
    rd(IDX_CONTROL_ZERO, e);
  endtask : look

  // Expectation is worked out after the wait, once a new pattern stands.
  task automatic lookx();
    repeat (6) @(posedge mclk);
    rd(IDX_CONTROL_ZERO, ctl0_exp());
  endtask : lookx

  task automatic rstchk();
    for (int j = 0; j < 6; j++) begin
      rd(idx[j], 8'h00);
    end
  endtask : rstchk

  // Each read answer is compared against the oldest noted value.
  always @(posedge mclk) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      check("read data", dat_o[7:0], expq.size() > 0 ? expq.pop_front() : 8'hxx);
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end

  initial begin
    r = $urandom(94);
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rstchk();
    $display("test reset values done");
    // Every data code once, random carriers, inversions and enable.
    for (int i = 0; i < 32; i++) begin
      r = $urandom;
      pat <= r[27:0];
      r = $urandom;
      c0 = r[7:0] & 8'hb1;
      c1 = r[15:8] & 8'h22;
      ds = 5'(i);
      lc = r[19:16];
      hc = r[23:20];
      cfg();
      look(ctl0_exp());
      rd(IDX_DATA_SOURCE, {3'b0, ds});
    end
    $display("test source selection done");
    // Leave each side with its carrier high, aligned and not.
    ds = SRC_SOFT;
    hc = CAR_CCP_BASE;
    lc = CAR_CCP_BASE + 4'h1;
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 2; a++) begin
        pat <= 28'h0;
        c1 = a ? (s ? 8'h10 : 8'h01) : 8'h00;
        c0 = 8'h80 | 8'(s);
        cfg();
        pat <= s ? 28'h1 : 28'h2;
        lookx();
        c0[0] = ~c0[0];
        wb(1'b1, IDX_CONTROL_ZERO, c0);
        look({c0[7:6], 1'(a), c0[4:0]});
        pat <= 28'h0;
        lookx();
        pat <= s ? 28'h2 : 28'h1;
        lookx();
      end
    end
    $display("test carrier alignment done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rstchk();
    $display("test mid-run reset done");
    conclude();
  end
endmodule : signal_keyer_tb
